// ---- cfg_loader_pkg.sv ----
package cfg_loader_pkg;
  // ==========================================================
  // register map (byte addresses on the apb side)
  // ==========================================================
  localparam logic [7:0] ctrl_addr = 8'h00;
  localparam logic [7:0] status_addr = 8'h04;
  localparam logic [7:0] data_addr = 8'h08;
  localparam logic [7:0] count_addr = 8'h0c;
  localparam logic [7:0] clkdiv_addr = 8'h10;

  // ctrl fields
  localparam int ctrl_start_bit = 0;
  localparam int ctrl_abort_bit = 1;
  localparam int ctrl_decomp_bit = 2;
  localparam int ctrl_crypt_bit = 3;
  localparam int ctrl_mon_bit = 4;
  localparam int ctrl_width_lsb = 5;

  // status fields
  localparam int st_busy_bit = 0;
  localparam int st_done_bit = 1;
  localparam int st_err_bit = 2;
  localparam int st_ready_bit = 3;
  localparam int st_status_bit = 4;
  localparam int st_cdone_bit = 5;

  localparam logic [1:0] width_8 = 2'h0;
  localparam logic [1:0] width_16 = 2'h1;
  localparam logic [1:0] width_32 = 2'h2;

  // ==========================================================
  // timing, 200 mhz system clock
  // ==========================================================
  localparam int clk_mhz = 200;
  localparam int req_low_us = 2;
  localparam int req_low_cyc = req_low_us * clk_mhz;
  localparam int st2ck_us = 2;
  localparam int st2ck_cyc = st2ck_us * clk_mhz;
  localparam int cf2ck_us = 1506;
  localparam int cf2ck_cyc = cf2ck_us * clk_mhz;
  localparam int cd2um_max_us = 437;
  localparam int cd2um_cyc = cd2um_max_us * clk_mhz;
  // fastest link clock: 125 mhz in x8/x16, 100 mhz in x32 -> divider floor
  localparam int fmax_narrow_mhz = 125;
  localparam int fmax_wide_mhz = 100;
  localparam int div_min_narrow = (clk_mhz + fmax_narrow_mhz - 1)
                                  / fmax_narrow_mhz;
  localparam int div_min_wide = (clk_mhz + fmax_wide_mhz - 1)
                                / fmax_wide_mhz;
  localparam logic [7:0] clkdiv_reset = 8'h04;
  localparam int final_falls = 2;

  typedef enum logic [3:0] {
    st_idle, st_req_low, st_wait_status, st_setup, st_data_lo,
    st_data_hi, st_flush, st_done_wait, st_tail, st_user_wait,
    st_error
  } load_state_t;
endpackage

// ---- pin_sync.sv ----
`timescale 1ns/1ps
// ==========================================================
// three-stage input synchroniser with agreement filter
// ==========================================================
module pin_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // a change counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level <= s3_r;
      end
    end
  end
endmodule

// ---- cfg_loader_host.sv ----
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
// ==========================================================
// Summary of operation
// - x8 ratio 1, or 2 when decompressing
// - x16 ratio 1, 2 crypt, 4 decompress
// - x32 ratio 1, 4 crypt, 8 decompress
// - hold each word for ratio clocks
// - keep clocking ratio minus one after last
// - lanes 7..0, 15..0 or 31..0
// - falling request starts reconfiguration
// - send whole stream; completion then rises
// - two falling clock edges after completion
// - drive clock to defined level afterwards
// - request low at least 2 us
// - wait 2 us after status, else 1506
// - clock at most 125 or 100 MHz
// - pause clock low, data valid first
// ==========================================================
module cfg_loader_host
  import cfg_loader_pkg::*;
#(
  parameter int cf2ck_cycles = cfg_loader_pkg::cf2ck_cyc,
  parameter int user_wait_cycles = cfg_loader_pkg::cd2um_cyc
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic cfg_clock,
  output logic [31:0] cfg_data,
  output logic cfg_req_n,
  input wire logic cfg_status_n,
  input wire logic cfg_done,
  input wire logic init_done
);
  import cfg_loader_pkg::*;

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic status_lvl;
  logic done_lvl;
  logic init_lvl;

  pin_sync u_sync_status (
    .pclk(pclk), .presetn(presetn), .pin(cfg_status_n), .level(status_lvl)
  );
  pin_sync u_sync_done (
    .pclk(pclk), .presetn(presetn), .pin(cfg_done), .level(done_lvl)
  );
  pin_sync u_sync_init (
    .pclk(pclk), .presetn(presetn), .pin(init_done), .level(init_lvl)
  );

  // ==========================================================
  // registers
  // ==========================================================
  load_state_t state_r;
  load_state_t state_nxt;
  logic decomp_r;
  logic crypt_r;
  logic mon_r;
  logic [1:0] width_r;
  logic [31:0] count_r;
  logic [31:0] sent_r;
  logic [31:0] word_r;
  logic word_full_r;
  logic [7:0] clkdiv_r;
  logic [7:0] half_r;
  logic [3:0] rep_r;
  logic [31:0] timer_r;
  logic done_r;
  logic err_r;
  logic start_r;
  logic abort_r;

  // ==========================================================
  // decode
  // ==========================================================
  wire wr_en = psel && penable && pwrite;
  wire wr_ctrl = wr_en && (paddr == ctrl_addr);
  wire wr_data = wr_en && (paddr == data_addr);
  wire wr_count = wr_en && (paddr == count_addr);
  wire wr_div = wr_en && (paddr == clkdiv_addr);
  wire addr_ok = (paddr == ctrl_addr) || (paddr == status_addr) ||
                 (paddr == data_addr) || (paddr == count_addr) ||
                 (paddr == clkdiv_addr);
  wire busy = (state_r != st_idle) && (state_r != st_error);
  // a data write into a full holding word stalls the bus
  wire data_stall = wr_data && word_full_r;
  wire [31:0] status_word = {26'h000_0000, done_lvl, status_lvl,
                             !word_full_r, err_r, done_r, busy};

  // clock-to-data ratio selection
  wire [3:0] ratio =
    (width_r == width_8)  ? (decomp_r ? 4'h2 : 4'h1) :
    (width_r == width_16) ? (decomp_r ? 4'h4 :
                             crypt_r ? 4'h2 : 4'h1) :
                            (decomp_r ? 4'h8 :
                             crypt_r ? 4'h4 : 4'h1);

  // half period never below the device's fastest allowed clock
  wire [7:0] div_floor = (width_r == width_32) ?
                         8'(div_min_wide) : 8'(div_min_narrow);
  wire [7:0] div_eff = (clkdiv_r < div_floor) ? div_floor : clkdiv_r;
  wire half_tick = (half_r == 8'h00);
  wire last_word = (sent_r + 32'h0000_0001) >= count_r;
  // with mon_r set, settle time counts from the status release, not from the request
  wire status_hold = (state_r == st_wait_status) && mon_r &&
                     !status_lvl;

  // unused upper lanes driven low
  wire [31:0] lane_mask = (width_r == width_8) ? 32'h0000_00ff :
                          (width_r == width_16) ? 32'h0000_ffff :
                          32'hffff_ffff;

  // ==========================================================
  // apb slave
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable ? 1'b0 :
                psel && penable && !pready && !data_stall;
      pslverr <= psel && penable && !pready && !data_stall && !addr_ok;
      case (paddr)
        ctrl_addr: prdata <= {25'h000_0000, width_r, mon_r, crypt_r,
                              decomp_r, 2'h0};
        status_addr: prdata <= status_word;
        count_addr: prdata <= count_r;
        clkdiv_addr: prdata <= {24'h00_0000, clkdiv_r};
        data_addr: prdata <= sent_r;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  wire wr_take = psel && penable && !pready && !data_stall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      decomp_r <= 1'b0;
      crypt_r <= 1'b0;
      mon_r <= 1'b1;
      width_r <= width_8;
      count_r <= 32'h0000_0000;
      clkdiv_r <= clkdiv_reset;
      start_r <= 1'b0;
      abort_r <= 1'b0;
    end else begin
      start_r <= wr_ctrl && wr_take && pwdata[ctrl_start_bit];
      abort_r <= wr_ctrl && wr_take && pwdata[ctrl_abort_bit];
      if (wr_ctrl && wr_take && !busy) begin
        decomp_r <= pwdata[ctrl_decomp_bit];
        crypt_r <= pwdata[ctrl_crypt_bit];
        mon_r <= pwdata[ctrl_mon_bit];
        width_r <= pwdata[ctrl_width_lsb +: 2];
      end
      if (wr_count && wr_take && !busy) begin
        count_r <= pwdata;
      end
      if (wr_div && wr_take) begin
        clkdiv_r <= pwdata[7:0];
      end
    end
  end

  // ==========================================================
  // load sequencer
  // ==========================================================
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      st_idle: if (start_r && count_r != 32'h0000_0000) begin
        state_nxt = st_req_low;
      end
      st_req_low: if (timer_r == 32'(req_low_cyc)) begin
        state_nxt = st_wait_status;
      end
      st_wait_status: begin
        if (mon_r ? (status_lvl && timer_r >= 32'(st2ck_cyc))
                  : (timer_r >= 32'(cf2ck_cycles))) begin
          state_nxt = st_setup;
        end
      end
      st_setup: if (word_full_r && half_tick) begin
        state_nxt = st_data_hi;
      end
      st_data_hi: if (half_tick) begin
        state_nxt = st_data_lo;
      end
      st_data_lo: if (half_tick) begin
        if (rep_r != 4'h1) begin
          state_nxt = st_data_hi;
        end else if (last_word) begin
          state_nxt = st_done_wait;
        end else begin
          state_nxt = st_setup;
        end
      end
      st_done_wait: if (done_lvl && half_tick) begin
        state_nxt = st_tail;
      end else if (timer_r >= 32'(cf2ck_cycles)) begin
        state_nxt = st_error;
      end
      st_tail: if (rep_r == 4'h0 && half_tick) begin
        state_nxt = st_user_wait;
      end
      st_user_wait: if (init_lvl || timer_r >= 32'(user_wait_cycles)) begin
        state_nxt = st_idle;
      end
      st_error: if (start_r) begin
        state_nxt = st_req_low;
      end
      default: state_nxt = st_idle;
    endcase
    // status dropping mid-load is a device-side error
    if (mon_r && !status_lvl && (state_r == st_setup ||
        state_r == st_data_hi || state_r == st_data_lo)) begin
      state_nxt = st_error;
    end
    if (abort_r) begin
      state_nxt = st_error;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= st_idle;
      timer_r <= 32'h0000_0000;
      half_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      timer_r <= (state_nxt != state_r || status_hold) ? 32'h0000_0000
                                         : timer_r + 32'h0000_0001;
      half_r <= (half_tick || state_nxt != state_r) ? div_eff - 8'h01
                                                    : half_r - 8'h01;
    end
  end

  // ==========================================================
  // pins, word holding and counters
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_req_n <= 1'b1;
      cfg_clock <= 1'b0;
      cfg_data <= 32'h0000_0000;
      word_r <= 32'h0000_0000;
      word_full_r <= 1'b0;
      sent_r <= 32'h0000_0000;
      rep_r <= 4'h0;
      done_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      cfg_req_n <= (state_nxt != st_req_low);
      // clock parks low between words and after the tail
      // clock trails the data by one cycle to give setup time
      cfg_clock <= (state_r == st_data_hi) ||
                   (state_nxt == st_tail && state_r == st_tail
                    && !cfg_clock && half_tick) ||
                   (state_r == st_tail && cfg_clock && !half_tick);
      if (state_r == st_setup && state_nxt == st_data_hi) begin
        cfg_data <= word_r & lane_mask;
        word_full_r <= 1'b0;
        rep_r <= ratio;
      end else if (wr_data && wr_take && !word_full_r) begin
        word_r <= pwdata;
        word_full_r <= 1'b1;
      end
      if (state_r == st_data_lo && half_tick) begin
        if (rep_r == 4'h1) begin
          sent_r <= sent_r + 32'h0000_0001;
          // extra clocks past the last word for decoding
          rep_r <= ratio - 4'h1;
        end else begin
          rep_r <= rep_r - 4'h1;
        end
      end
      if (state_r == st_done_wait && state_nxt == st_tail) begin
        rep_r <= rep_r + 4'(final_falls);
      end else if (state_r == st_tail && cfg_clock && half_tick) begin
        rep_r <= rep_r - 4'h1;
      end
      if (state_nxt == st_req_low && state_r != st_req_low) begin
        sent_r <= 32'h0000_0000;
        done_r <= 1'b0;
        err_r <= 1'b0;
        word_full_r <= 1'b0;
      end
      if (state_r == st_user_wait && state_nxt == st_idle) begin
        done_r <= 1'b1;
      end
      if (state_nxt == st_error && state_r != st_error) begin
        err_r <= 1'b1;
      end
    end
  end
endmodule

// ---- cfg_loader_checker.sv ----
`timescale 1ns/1ps
// ==========================================================
// link and apb timing properties
// ==========================================================
module cfg_loader_checker
  import cfg_loader_pkg::*;
#(
  parameter int cf2ck_cycles = 50,
  parameter int user_wait_cycles = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cfg_clock,
  input wire logic [31:0] cfg_data,
  input wire logic cfg_req_n,
  input wire logic cfg_status_n,
  input wire logic cfg_done
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic clk_q, first_r;
  logic [9:0] st_hi;
  logic [10:0] low_cnt;
  logic [1:0] fall_cnt;
  wire clk_rise = cfg_clock && !clk_q;
  wire clk_fall = !cfg_clock && clk_q;
  // counters saturate so long idle stretches never wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_q <= 1'b0;
      first_r <= 1'b0;
      st_hi <= '0;
      low_cnt <= '0;
      fall_cnt <= '0;
    end else begin
      clk_q <= cfg_clock;
      first_r <= !cfg_req_n || (first_r && !clk_rise);
      st_hi <= !cfg_status_n ? '0 : st_hi + 10'(st_hi != 10'h3ff);
      low_cnt <= cfg_req_n ? '0 : low_cnt + 11'(low_cnt != 11'h7ff);
      fall_cnt <= !cfg_done ? '0 : fall_cnt + 2'(clk_fall && fall_cnt != 2'h3);
    end
  end
  property p_req_width;
    $rose(cfg_req_n) |-> low_cnt >= 11'h190;
  endproperty
  property p_clk_half;
    $changed(cfg_clock) |=> $stable(cfg_clock);
  endproperty
  property p_data_low;
    $changed(cfg_data) |-> !cfg_clock;
  endproperty
  property p_data_setup;
    $rose(cfg_clock) |-> $stable(cfg_data);
  endproperty
  property p_first_edge;
    $rose(cfg_clock) && first_r |-> st_hi >= 10'h190;
  endproperty
  property p_stop_on_fail;
    !cfg_status_n [*8] |-> !$rose(cfg_clock);
  endproperty
  property p_tail;
    $rose(cfg_done) |-> ##[1:400] fall_cnt >= 2'h2;
  endproperty
  property p_clk_gated;
    !cfg_req_n |-> !cfg_clock;
  endproperty
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_req_width: assert property (p_req_width)
    else $error("request pulse too short");
  a_clk_half: assert property (p_clk_half)
    else $error("link clock half period too short");
  a_data_low: assert property (p_data_low)
    else $error("data moved while clock high");
  a_data_setup: assert property (p_data_setup)
    else $error("data moved at clock rise");
  a_first_edge: assert property (p_first_edge)
    else $error("first clock too soon after status");
  a_stop_on_fail: assert property (p_stop_on_fail)
    else $error("clocking while status low");
  a_tail: assert property (p_tail)
    else $error("missing falling edges after completion");
  a_clk_gated: assert property (p_clk_gated)
    else $error("clock high during request");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (p_err_ready)
    else $error("pslverr without pready");
  c_done: cover property ($rose(cfg_done));
  c_req: cover property ($fell(cfg_req_n));
  c_first: cover property ($rose(cfg_clock) && first_r);
  c_slverr: cover property (pslverr);
endmodule

bind cfg_loader_host cfg_loader_checker #(
  .cf2ck_cycles(cf2ck_cycles),
  .user_wait_cycles(user_wait_cycles)
) chk (.pclk, .presetn, .pready, .pslverr, .cfg_clock, .cfg_data,
  .cfg_req_n, .cfg_status_n, .cfg_done);

// ---- cfg_device_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// behavioural configuration target
// ==========================================================
module cfg_device_model #(
  parameter int st_dly = 100
) (
  input wire logic pclk,
  input wire logic cfg_req_n,
  input wire logic cfg_clock,
  input wire logic pull_low,
  input wire logic [31:0] cfg_data,
  input int need,
  input int ratio,
  output logic cfg_status_n,
  output logic cfg_done,
  output logic init_done,
  output logic [31:0] last_word,
  output int rises,
  output int errs
);
  logic low_r = 1'b1;
  int cnt = 0;
  int falls = 0;
  // open drain: either party may pull low
  assign cfg_status_n = !(low_r || pull_low);
  initial begin
    cfg_done = 1'b0;
    init_done = 1'b0;
    last_word = 32'h0000_0000;
    rises = 0;
    errs = 0;
  end
  // status delay scaled down to keep runs short
  always @(posedge pclk) begin
    if (!cfg_req_n) begin
      low_r <= 1'b1;
      cnt <= 0;
      cfg_done <= 1'b0;
      init_done <= 1'b0;
      rises <= 0;
      falls <= 0;
    end else if (low_r) begin
      cnt <= cnt + 1;
      if (cnt == st_dly)
        low_r <= 1'b0;
    end
  end
  always @(posedge cfg_clock) begin
    if (cfg_status_n && !cfg_done) begin
      if (rises % ratio != 0 && cfg_data !== last_word)
        errs <= errs + 1;
      last_word <= cfg_data;
      rises <= rises + 1;
      if (rises + 1 == need)
        cfg_done <= 1'b1;
    end
  end
  always @(negedge cfg_clock) begin
    if (cfg_done) begin
      falls <= falls + 1;
      if (falls == 1)
        init_done <= 1'b1;
    end
  end
endmodule

// ---- fast_parallel_config_loader_test.sv ----
`timescale 1ns/1ps
// ==========================================================
// loads in every width and mode, status-drop error, refusals
// ==========================================================
module fast_parallel_config_loader_test;
  import cfg_loader_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pull_low = 1'b0;
  logic [31:0] prdata, cfg_data, last_word, rdat;
  logic pready, pslverr, cfg_clock, cfg_req_n, cfg_status_n;
  logic cfg_done, init_done, rerr;
  int need = 0;
  int ratio = 1;
  int rises, errs, err_count, total_checks, cyc;

  initial begin
    forever #2.5 pclk = ~pclk;
  end

  cfg_loader_host #(.cf2ck_cycles(50), .user_wait_cycles(20)) uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cfg_clock, .cfg_data, .cfg_req_n, .cfg_status_n,
    .cfg_done, .init_done);
  cfg_device_model #(.st_dly(100)) dev (
    .pclk, .cfg_req_n, .cfg_clock, .pull_low, .cfg_data, .need, .ratio,
    .cfg_status_n, .cfg_done, .init_done, .last_word, .rises, .errs);

  task finish_test();
    if (err_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      finish_test();
    end
  end

  task chk(input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, s, x);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function int rat(int w, bit dc, bit cr);
    if (w == 0)
      return dc ? 2 : 1;
    if (w == 1)
      return dc ? 4 : (cr ? 2 : 1);
    return dc ? 8 : (cr ? 4 : 1);
  endfunction

  task run(input int w, input bit dc, input bit cr, input bit ab);
    logic [31:0] word, mask;
    ratio = rat(w, dc, cr);
    need = 3 * ratio;
    mask = w == 0 ? 32'h0000_00ff : w == 1 ? 32'h0000_ffff : '1;
    apb(1'b1, count_addr, 32'h0000_0003);
    apb(1'b1, ctrl_addr, 32'((w << ctrl_width_lsb) | (cr << ctrl_crypt_bit)
      | (dc << ctrl_decomp_bit) | (1 << ctrl_mon_bit) | 1));
    for (int i = 0; i < (ab ? 1 : 3); i++) begin
      word = 32'hc3a5_5a3c ^ (i * 32'h0101_0101);
      apb(1'b1, data_addr, word);
    end
    if (ab) begin
      wait (rises > 0);
      @(posedge pclk);
      pull_low <= 1'b1;
    end
    do apb(1'b0, status_addr, 32'h0000_0000);
    while (rdat[st_busy_bit] !== 1'b0 ||
      (rdat[st_done_bit] !== 1'b1 && rdat[st_err_bit] !== 1'b1));
    pull_low <= 1'b0;
    if (ab) begin
      chk(rdat[st_err_bit], 1);
    end else begin
      chk(rdat[st_done_bit], 1);
      chk(rdat[st_err_bit], 0);
      chk(rdat[st_cdone_bit], 1);
      chk(rises, need);
      chk(errs, 0);
      chk(last_word & mask, word & mask);
      chk(last_word & ~mask, 0);
      chk(init_done, 1);
      apb(1'b0, data_addr, 32'h0000_0000);
      chk(rdat, 32'h0000_0003);
    end
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, status_addr, 32'h0000_0000);
    chk(rdat[2:0], 0);
    apb(1'b0, clkdiv_addr, 32'h0000_0000);
    chk(rdat, 32'h0000_0004);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk(rerr, 1);
    chk(rdat, 0);
    // below the floor: the link must still respect its top rate
    apb(1'b1, clkdiv_addr, 32'h0000_0001);
    run(2, 1'b1, 1'b0, 1'b1);
    for (int w = 0; w < 3; w++) begin
      for (int m = 0; m < 4; m++) begin
        run(w, m[1], m[0], 1'b0);
      end
    end
    finish_test();
  end
endmodule
